/* common/cics_pkg.sv */
// Package of constants and types for the call/interrupt context switcher
package cics_pkg;
  localparam int PC_W = 24;
  localparam int LCTX_W = 8;
  localparam int SPTR_W = 16;
  localparam int SPAGE_W = 7;
  localparam int NUM_ISR = 32;
  localparam int NUM_HW_ISR = 27;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PC = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RET_PAIR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DSP = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SSP = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SPH = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ST0 = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_ST1 = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_ST2 = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_DBST = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_REG0 = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_REG1 = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_SWI = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_TARGET = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_RSTVEC = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_LCTX = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_IVP = 8'h44;
  // CTRL bit positions (CALL/RET/RETI write strobes, self clearing; GIM a held mask bit)
  localparam int CTRL_CALL = 0;
  localparam int CTRL_RET = 1;
  localparam int CTRL_RETI = 2;
  localparam int CTRL_GIM = 3;
  // Reset vector stack configuration field
  localparam int CFG_HI = 29;
  localparam int CFG_LO = 28;
  localparam logic [1:0] CFG_FAST = 2'b00;
  localparam logic [1:0] CFG_DUAL_SLOW = 2'b01;
  localparam logic [1:0] CFG_SINGLE = 2'b10;
  // Reset values
  localparam logic [SPTR_W-1:0] SPTR_RST = 16'h0000;
  localparam logic [31:0] RSTVEC_RST = 32'h0000_0000;
  localparam logic [PC_W-1:0] IVP_RST = 24'hff_ff00;
  localparam logic [1:0] EXT_HOLD_CYC = 2'd3;
  // Vector entries are 8 memory words apart
  localparam int VEC_SHIFT = 3;
  // Hardware priority order, highest first
  localparam logic [4:0] PRIO_ORDER [NUM_HW_ISR] = '{
    5'd0, 5'd1, 5'd24, 5'd2, 5'd16, 5'd3, 5'd4, 5'd5, 5'd17, 5'd6,
    5'd7, 5'd8, 5'd18, 5'd9, 5'd10, 5'd11, 5'd19, 5'd12, 5'd13,
    5'd20, 5'd21, 5'd14, 5'd15, 5'd22, 5'd23, 5'd25, 5'd26};
  typedef enum logic [3:0] {
    CS_IDLE, CS_FLUSH, CS_PUSH, CS_LOAD, CS_VEC, CS_VEC_WAIT,
    CS_POP, CS_POP_WAIT, CS_DONE
  } cics_state_t;
  typedef enum logic [1:0] {OP_CALL, OP_IRQ, OP_RET, OP_RETI}
    cics_op_t;
endpackage : cics_pkg

/* verilog/cics_core.sv */
// Call and interrupt context save/restore unit with APB registers
`timescale 1ns/1ps
module cics_core
  import cics_pkg::*;
#(
  parameter int NUM_IRQ = NUM_ISR
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_IRQ-1:0] irq_pin,
  input wire logic instr_done,
  output logic flush_req,
  output logic irq_ack,
  output logic [4:0] irq_num,
  output logic mem_req,
  output logic mem_we,
  output logic mem_sys,
  output logic [22:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic busy
);
  // Frame layout: one stack slot per word pair, system holds high half
  // slot0: loop ctx/ret addr (or old pair), slot1: st0/st1, slot2: st2/dbg
  // Top slot pushed first, so a return pops slot0 (address) first
  logic [NUM_IRQ-1:0] irq_s1_q, irq_s2_q, irq_s3_q;
  logic [1:0] rel_cnt_q;
  logic stk_blk_q, dsp_wr_q, ssp_wr_q, gim_q;
  logic [PC_W-1:0] pc_q, target_q, ivp_q;
  logic [LCTX_W-1:0] lctx_q, flow_ctx_q;
  logic [PC_W-1:0] ret_addr_q;
  logic [SPTR_W-1:0] dsp_q, ssp_q;
  logic [SPAGE_W-1:0] sph_q;
  logic [15:0] st0_q, st1_q, st2_q, dbg_q;
  logic [31:0] ier_q, swi_q, rstvec_q;
  logic [1:0] cfg_q;
  cics_state_t st_q;
  cics_op_t op_q;
  logic [1:0] slot_q, nslot_q;
  logic half_q;
  logic [4:0] num_q;
  logic [15:0] hold_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, flush_q, ack_q, mreq_q, mwe_q, msys_q;
  logic [22:0] maddr_q;
  logic [15:0] mwdata_q;
  logic cmd_call_q, cmd_ret_q, cmd_reti_q;
  logic busy_q;

  wire setup = psel && !penable;
  // Writes land at the access edge, where the master sees pready
  wire wr = psel && penable && pready_q && pwrite;
  wire fast = (cfg_q == CFG_FAST);
  wire ext_live = (rel_cnt_q == EXT_HOLD_CYC);
  wire [31:0] hw_req = ext_live ? 32'(irq_s3_q) : 32'h0;
  wire [31:0] enabled = hw_req & (gim_q ? 32'h0 : ier_q);
  logic [4:0] hw_sel;
  logic hw_hit;
  always_comb begin
    hw_sel = 5'h00;
    hw_hit = 1'b0;
    for (int i = NUM_HW_ISR - 1; i >= 0; i--) begin
      if (enabled[PRIO_ORDER[i]] ||
          (hw_req[PRIO_ORDER[i]] && PRIO_ORDER[i] < 5'd2)) begin
        hw_sel = PRIO_ORDER[i];
        hw_hit = 1'b1;
      end
    end
  end
  logic [4:0] sw_sel;
  logic sw_hit;
  always_comb begin
    sw_sel = 5'h00;
    sw_hit = 1'b0;
    for (int i = NUM_ISR - 1; i >= 0; i--) begin
      if (swi_q[i]) begin
        sw_sel = 5'(i);
        sw_hit = 1'b1;
      end
    end
  end
  wire irq_go = !stk_blk_q && (hw_hit || sw_hit);
  wire [4:0] irq_pick = sw_hit ? sw_sel : hw_sel;
  wire [1:0] frames = (op_q == OP_IRQ || op_q == OP_RETI) ? 2'd3 : 2'd1;

  // Push data for the current slot and half
  wire [15:0] slot_lo = fast ? ret_addr_q[15:0] : pc_q[15:0];
  logic [15:0] push_word;
  always_comb begin
    push_word = 16'h0000;
    case (slot_q)
      2'd0: begin
        if (fast)
          push_word = half_q ? {flow_ctx_q, ret_addr_q[23:16]} : slot_lo;
        else
          push_word = half_q ? {lctx_q, pc_q[23:16]} : slot_lo;
      end
      2'd1: push_word = half_q ? st0_q : st1_q;
      2'd2: push_word = half_q ? st2_q : dbg_q;
      default: push_word = 16'h0000;
    endcase
  end

  wire [SPTR_W-1:0] ptr_now = half_q ? ssp_q : dsp_q;
  wire [SPTR_W-1:0] ptr_dec = ptr_now - 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_s1_q <= '0;
      irq_s2_q <= '0;
      irq_s3_q <= '0;
      rel_cnt_q <= 2'd0;
    end else begin
      irq_s1_q <= irq_pin;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
      if (rel_cnt_q != EXT_HOLD_CYC)
        rel_cnt_q <= rel_cnt_q + 2'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= CS_IDLE;
      op_q <= OP_CALL;
      slot_q <= 2'd0;
      nslot_q <= 2'd0;
      half_q <= 1'b1;
      num_q <= 5'h00;
      hold_q <= 16'h0000;
      pc_q <= '0;
      lctx_q <= '0;
      flow_ctx_q <= '0;
      ret_addr_q <= '0;
      dsp_q <= SPTR_RST;
      ssp_q <= SPTR_RST;
      sph_q <= '0;
      st0_q <= 16'h0000;
      st1_q <= 16'h0000;
      st2_q <= 16'h0000;
      dbg_q <= 16'h0000;
      ier_q <= 32'h0000_0000;
      swi_q <= 32'h0000_0000;
      rstvec_q <= RSTVEC_RST;
      cfg_q <= CFG_FAST;
      target_q <= '0;
      ivp_q <= IVP_RST;
      stk_blk_q <= 1'b1;
      dsp_wr_q <= 1'b0;
      ssp_wr_q <= 1'b0;
      gim_q <= 1'b1;
      flush_q <= 1'b0;
      ack_q <= 1'b0;
      irq_num <= 5'h00;
      mreq_q <= 1'b0;
      mwe_q <= 1'b0;
      msys_q <= 1'b0;
      maddr_q <= '0;
      mwdata_q <= 16'h0000;
      cmd_call_q <= 1'b0;
      cmd_ret_q <= 1'b0;
      cmd_reti_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      if (dsp_wr_q && ssp_wr_q)
        stk_blk_q <= 1'b0;
      if (wr) begin
        case (paddr)
          OFS_CTRL: begin
            cmd_call_q <= cmd_call_q | pwdata[CTRL_CALL];
            cmd_ret_q <= cmd_ret_q | pwdata[CTRL_RET];
            cmd_reti_q <= cmd_reti_q | pwdata[CTRL_RETI];
            gim_q <= pwdata[CTRL_GIM];
          end
          OFS_PC: pc_q <= pwdata[PC_W-1:0];
          OFS_RET_PAIR: begin
            flow_ctx_q <= pwdata[31:24];
            ret_addr_q <= pwdata[23:0];
          end
          OFS_DSP: begin
            dsp_q <= pwdata[15:0];
            dsp_wr_q <= 1'b1;
          end
          OFS_SSP: begin
            ssp_q <= pwdata[15:0];
            ssp_wr_q <= 1'b1;
          end
          OFS_SPH: sph_q <= pwdata[SPAGE_W-1:0];
          OFS_ST0: st0_q <= pwdata[15:0];
          OFS_ST1: st1_q <= pwdata[15:0];
          OFS_ST2: st2_q <= pwdata[15:0];
          OFS_DBST: dbg_q <= pwdata[15:0];
          OFS_IRQ_ENABLE_REG0: ier_q[15:0] <= pwdata[15:0];
          OFS_IRQ_ENABLE_REG1: ier_q[31:16] <= pwdata[15:0];
          OFS_SWI: swi_q <= swi_q | pwdata;
          OFS_TARGET: target_q <= pwdata[PC_W-1:0];
          OFS_RSTVEC: begin
            rstvec_q <= pwdata;
            cfg_q <= pwdata[CFG_HI:CFG_LO];
          end
          OFS_LCTX: lctx_q <= pwdata[LCTX_W-1:0];
          OFS_IVP: ivp_q <= pwdata[PC_W-1:0];
          default: ;
        endcase
      end
      case (st_q)
        CS_IDLE: begin
          slot_q <= 2'd0;
          half_q <= 1'b1;
          busy_q <= irq_go || cmd_call_q || cmd_ret_q || cmd_reti_q;
          if (irq_go) begin
            op_q <= OP_IRQ;
            slot_q <= 2'd2;
            num_q <= irq_pick;
            irq_num <= irq_pick;
            ack_q <= 1'b1;
            if (sw_hit)
              swi_q[sw_sel] <= 1'b0;
            flush_q <= 1'b1;
            st_q <= CS_FLUSH;
          end else if (cmd_call_q) begin
            cmd_call_q <= 1'b0;
            op_q <= OP_CALL;
            st_q <= CS_PUSH;
          end else if (cmd_ret_q || cmd_reti_q) begin
            op_q <= cmd_reti_q ? OP_RETI : OP_RET;
            cmd_ret_q <= 1'b0;
            cmd_reti_q <= 1'b0;
            if (fast) begin
              pc_q <= ret_addr_q;
              lctx_q <= flow_ctx_q;
              slot_q <= 2'd0;
            end else begin
              slot_q <= 2'd0;
            end
            st_q <= CS_POP;
          end
        end
        CS_FLUSH: if (instr_done) begin
          flush_q <= 1'b0;
          st_q <= CS_PUSH;
        end
        CS_PUSH: begin
          mreq_q <= 1'b1;
          mwe_q <= 1'b1;
          msys_q <= half_q;
          maddr_q <= {sph_q, ptr_dec};
          mwdata_q <= push_word;
          // Each pointer moves once per slot, linked stack included
          if (half_q)
            ssp_q <= ptr_dec;
          else
            dsp_q <= ptr_dec;
          st_q <= CS_VEC_WAIT;
          nslot_q <= slot_q;
        end
        CS_VEC_WAIT: if (mem_ack) begin
          mreq_q <= 1'b0;
          if (op_q == OP_CALL || op_q == OP_IRQ) begin
            if (half_q) begin
              half_q <= 1'b0;
              st_q <= CS_PUSH;
            end else if (nslot_q != 2'd0) begin
              half_q <= 1'b1;
              slot_q <= nslot_q - 2'd1;
              st_q <= CS_PUSH;
            end else
              st_q <= CS_LOAD;
          end else
            st_q <= CS_VEC;
        end
        CS_LOAD: begin
          if (fast) begin
            ret_addr_q <= pc_q;
            flow_ctx_q <= lctx_q;
          end
          lctx_q <= '0;
          if (op_q == OP_IRQ) begin
            mreq_q <= 1'b1;
            mwe_q <= 1'b0;
            msys_q <= 1'b0;
            maddr_q <= 23'(ivp_q + (24'(num_q) << VEC_SHIFT));
            st_q <= CS_VEC;
          end else begin
            pc_q <= target_q;
            st_q <= CS_DONE;
          end
        end
        CS_VEC: if (mem_ack) begin
          mreq_q <= 1'b0;
          pc_q <= {pc_q[23:16], mem_rdata};
          st_q <= CS_DONE;
        end
        CS_POP: begin
          mreq_q <= 1'b1;
          mwe_q <= 1'b0;
          msys_q <= !half_q;
          maddr_q <= {sph_q, half_q ? dsp_q : ssp_q};
          st_q <= CS_POP_WAIT;
        end
        CS_POP_WAIT: if (mem_ack) begin
          mreq_q <= 1'b0;
          if (half_q) begin
            hold_q <= mem_rdata;
            dsp_q <= dsp_q + 16'h0001;
            half_q <= 1'b0;
            st_q <= CS_POP;
          end else begin
            ssp_q <= ssp_q + 16'h0001;
            case (slot_q)
              2'd0: begin
                if (fast) begin
                  ret_addr_q <= {mem_rdata[7:0], hold_q};
                  flow_ctx_q <= mem_rdata[15:8];
                end else begin
                  pc_q <= {mem_rdata[7:0], hold_q};
                  lctx_q <= mem_rdata[15:8];
                end
              end
              2'd1: begin
                st1_q <= hold_q;
                st0_q <= mem_rdata;
              end
              default: begin
                dbg_q <= hold_q;
                st2_q <= mem_rdata;
              end
            endcase
            if (slot_q + 2'd1 < frames) begin
              slot_q <= slot_q + 2'd1;
              half_q <= 1'b1;
              st_q <= CS_POP;
            end else
              st_q <= CS_DONE;
          end
        end
        CS_DONE: begin
          busy_q <= 1'b0;
          st_q <= CS_IDLE;
        end
        default: begin
          busy_q <= 1'b0;
          st_q <= CS_IDLE;
        end
      endcase
    end
  end

  // Register read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_mux = {28'h0, gim_q, cmd_reti_q, cmd_ret_q, cmd_call_q};
      OFS_STATUS: rd_mux = {24'h0, cfg_q, stk_blk_q, 1'b0,
                            4'(st_q)};
      OFS_PC: rd_mux = {8'h00, pc_q};
      OFS_RET_PAIR: rd_mux = {flow_ctx_q, ret_addr_q};
      OFS_DSP: rd_mux = {16'h0000, dsp_q};
      OFS_SSP: rd_mux = {16'h0000, ssp_q};
      OFS_SPH: rd_mux = {25'h0, sph_q};
      OFS_ST0: rd_mux = {16'h0000, st0_q};
      OFS_ST1: rd_mux = {16'h0000, st1_q};
      OFS_ST2: rd_mux = {16'h0000, st2_q};
      OFS_DBST: rd_mux = {16'h0000, dbg_q};
      OFS_IRQ_ENABLE_REG0: rd_mux = {16'h0000, ier_q[15:0]};
      OFS_IRQ_ENABLE_REG1: rd_mux = {16'h0000, ier_q[31:16]};
      OFS_SWI: rd_mux = swi_q;
      OFS_TARGET: rd_mux = {8'h00, target_q};
      OFS_RSTVEC: rd_mux = rstvec_q;
      OFS_LCTX: rd_mux = {24'h0, lctx_q};
      OFS_IVP: rd_mux = {8'h00, ivp_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  wire mapped = (paddr <= OFS_IVP) && (paddr[1:0] == 2'b00);

  // Zero wait state: pready rises for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup && !pwrite)
        prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign flush_req = flush_q;
  assign irq_ack = ack_q;
  assign mem_req = mreq_q;
  assign mem_we = mwe_q;
  assign mem_sys = msys_q;
  assign mem_addr = maddr_q;
  assign mem_wdata = mwdata_q;
  assign busy = busy_q;
endmodule : cics_core

/* tb/cics_core_asserts.sv */
// Port timing checker for the context switch unit
`timescale 1ns/1ps
module cics_core_asserts
  import cics_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flush_req,
  input wire logic instr_done,
  input wire logic irq_ack,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_sys,
  input wire logic [22:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack
);
  logic [SPAGE_W-1:0] page_q;
  logic dsp_set_q;
  logic ssp_set_q;
  wire apb_wr = psel && penable && pready && pwrite;
  // Shadow of what software wrote, to judge pushes and gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= '0;
      dsp_set_q <= 1'b0;
      ssp_set_q <= 1'b0;
    end else if (apb_wr) begin
      if (paddr == OFS_SPH) page_q <= pwdata[SPAGE_W-1:0];
      if (paddr == OFS_DSP) dsp_set_q <= 1'b1;
      if (paddr == OFS_SSP) ssp_set_q <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_mem_wait;
    mem_req && !mem_ack;
  endsequence
  sequence s_sys_push;
    mem_req && mem_ack && mem_we && mem_sys;
  endsequence
  chk_apb_answer: assert property (s_setup |=> penable && pready)
    else $error("no answer one cycle after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error flag outside access phase");
  chk_page_fixed:
    assert property (mem_req && mem_we |-> mem_addr[22:16] == page_q)
    else $error("push left the software page");
  chk_irq_blocked:
    assert property (!(dsp_set_q && ssp_set_q) |-> !irq_ack)
    else $error("interrupt taken before both pointers set");
  chk_ack_flush:
    assert property (irq_ack |-> ##[0:1] flush_req)
    else $error("no flush after acknowledge");
  chk_flush_first:
    assert property (flush_req && !instr_done |-> !mem_req)
    else $error("context saved before flush completed");
  chk_req_held: assert property (s_mem_wait |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata) && $stable(mem_sys))
    else $error("memory request changed before ack");
  chk_pair_push:
    assert property (s_sys_push |=> ##[0:6] (mem_req && mem_we && !mem_sys))
    else $error("system push without data push");
  chk_ack_pulse: assert property (irq_ack |=> !irq_ack)
    else $error("acknowledge longer than one cycle");
endmodule : cics_core_asserts

bind cics_core cics_core_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .flush_req(flush_req), .instr_done(instr_done),
  .irq_ack(irq_ack), .mem_req(mem_req), .mem_we(mem_we),
  .mem_sys(mem_sys), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_ack(mem_ack)
);

/* tb/cics_stack_mem.sv */
// Behavioural data memory holding both stacks and the vector table
`timescale 1ns/1ps
module cics_stack_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_sys,
  input wire logic [22:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] store [logic [23:0]];
  logic [23:0] key;
  int lat;
  int waited;
  assign key = {mem_sys, mem_addr};
  // Latency cycles 0..3 so both prompt and slow answers occur
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0;
      lat = 0;
      waited = 0;
    end else if (mem_req && !mem_ack && waited >= lat) begin
      mem_ack <= 1'b1;
      waited = 0;
      lat = (lat + 1) % 4;
      if (mem_we) store[key] = mem_wdata;
      else if (store.exists(key)) mem_rdata <= store[key];
      // Unwritten words stand in for the preset vector table
      else mem_rdata <= mem_addr[15:0] ^ 16'h3c3c;
    end else begin
      mem_ack <= 1'b0;
      // No stale word left on the data lines
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) waited++;
    end
  end
endmodule : cics_stack_mem

/* tb/test_call_interrupt_context_switch.sv */
// Self-checking bench for the context switch unit
`timescale 1ns/1ps
module test_call_interrupt_context_switch;
  import cics_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [NUM_ISR-1:0] irq_pin = '0;
  logic instr_done = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, flush_req, irq_ack, mem_req, mem_we, mem_sys;
  logic mem_ack, busy, err;
  logic [4:0] irq_num, last_num;
  logic [22:0] mem_addr, sys_addr, dat_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [31:0] rdv;
  int num_errors = 0;
  int checked = 0;
  int acks = 0;
  int writes = 0;

  cics_core u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_pin(irq_pin),
    .instr_done(instr_done), .flush_req(flush_req), .irq_ack(irq_ack),
    .irq_num(irq_num), .mem_req(mem_req), .mem_we(mem_we),
    .mem_sys(mem_sys), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy)
  );
  cics_stack_mem u_mem (
    .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_sys(mem_sys), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  always #2 pclk = ~pclk;
  always @(posedge pclk) instr_done <= flush_req;
  // Requests drop at acknowledge so only one service is entered
  always @(posedge pclk) begin
    if (irq_ack === 1'b1) begin
      acks++;
      last_num = irq_num;
      irq_pin <= '0;
    end
    if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b1) begin
      writes++;
      if (mem_sys) sys_addr = mem_addr;
      else dat_addr = mem_addr;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rdv = prdata;
    err = pslverr;
    if (n >= 64) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdv, exp);
  endtask : rd

  // Lead-in covers the request synchroniser before busy shows
  task automatic settle();
    int n;
    n = 0;
    repeat (8) @(posedge pclk);
    while (busy !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) num_errors++;
  endtask : settle

  task automatic call_ret(input logic fast);
    wr(OFS_PC, 32'h0012_3456);
    wr(OFS_LCTX, 32'h5a);
    writes = 0;
    wr(OFS_CTRL, 32'h1 << CTRL_CALL);
    settle();
    rd(OFS_PC, 32'h0000_4000);
    rd(OFS_LCTX, 32'h0);
    rd(OFS_DSP, 32'h00ff);
    rd(OFS_SSP, 32'hffff);
    check(32'(writes), 32'h2);
    check({9'h0, sys_addr}, 32'h0012_ffff);
    check({9'h0, dat_addr}, 32'h0012_00ff);
    rd(OFS_RET_PAIR, fast ? 32'h5a12_3456 : 32'h0);
    wr(OFS_LCTX, 32'h33);
    wr(OFS_CTRL, 32'h1 << CTRL_RET);
    settle();
    rd(OFS_PC, 32'h0012_3456);
    rd(OFS_LCTX, 32'h5a);
    rd(OFS_DSP, 32'h0100);
    rd(OFS_SSP, 32'h0);
    rd(OFS_RET_PAIR, 32'h0);
  endtask : call_ret

  task automatic isr(input logic fast, input logic [4:0] num);
    logic [15:0] vec;
    vec = (IVP_RST[15:0] + (16'(num) << VEC_SHIFT)) ^ 16'h3c3c;
    wr(OFS_CTRL, 32'h1 << CTRL_GIM);
    wr(OFS_IRQ_ENABLE_REG0, 32'hffff_ffff);
    wr(OFS_IRQ_ENABLE_REG1, 32'hffff_ffff);
    writes = 0;
    wr(OFS_CTRL, 32'h0);
    settle();
    check({27'h0, last_num}, {27'h0, num});
    check(32'(writes), 32'h6);
    rd(OFS_DSP, 32'h00fd);
    rd(OFS_SSP, 32'h01fd);
    rd(OFS_LCTX, 32'h0);
    rd(OFS_RET_PAIR, fast ? 32'h5a12_3456 : 32'h0);
    apb(1'b0, OFS_PC, 32'h0);
    check({16'h0, rdv[15:0]}, {16'h0, vec});
    // Handler disables further sources and dirties status 0
    wr(OFS_IRQ_ENABLE_REG0, 32'h0);
    wr(OFS_IRQ_ENABLE_REG1, 32'h0);
    wr(OFS_ST0, 32'h0);
    wr(OFS_CTRL, 32'h1 << CTRL_RETI);
    settle();
    rd(OFS_ST0, 32'h1111);
    rd(OFS_DBST, 32'h2222);
    rd(OFS_PC, 32'h0012_3456);
    rd(OFS_LCTX, 32'h5a);
    rd(OFS_DSP, 32'h0100);
    rd(OFS_SSP, 32'h0200);
  endtask : isr

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_DSP, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(OFS_SPH, 32'h12);
    wr(OFS_DSP, 32'h0100);
    wr(OFS_TARGET, 32'h0000_4000);
    for (int m = 0; m < 3; m++) begin
      wr(OFS_RSTVEC, {2'b00, 2'(m), 28'h0});
      call_ret(m == 0);
    end
    wr(OFS_ST0, 32'h1111);
    wr(OFS_DBST, 32'h2222);
    wr(OFS_IRQ_ENABLE_REG0, 32'hffff_ffff);
    wr(OFS_IRQ_ENABLE_REG1, 32'hffff_ffff);
    wr(OFS_CTRL, 32'h0);
    irq_pin[24] <= 1'b1;
    irq_pin[2] <= 1'b1;
    repeat (30) @(posedge pclk);
    check(32'(acks), 32'h0);
    wr(OFS_CTRL, 32'h1 << CTRL_GIM);
    wr(OFS_SSP, 32'h0200);
    repeat (30) @(posedge pclk);
    check(32'(acks), 32'h0);
    wr(OFS_RSTVEC, 32'h0);
    isr(1'b1, 5'd24);
    wr(OFS_RSTVEC, 32'h1000_0000);
    irq_pin[5] <= 1'b1;
    isr(1'b0, 5'd5);
    end_sim();
  end

  // A hang is cut off well beyond the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_sim();
  end
endmodule : test_call_interrupt_context_switch
